// File: core/ssc_pkg.sv
// Constants for the serial port client hold control block.
// Assumes an 8-bit register port and a 125 MHz system clock.
package ssc_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFS_DBUF      = 12'h18C;
    localparam logic [11:0] OFS_CADDR     = 12'h18D;
    localparam logic [11:0] OFS_AMASK     = 12'h18E;
    localparam logic [11:0] OFS_STAT      = 12'h18F;
    localparam logic [11:0] OFS_CTL1      = 12'h190;
    localparam logic [11:0] OFS_CTL2      = 12'h191;
    localparam logic [11:0] OFS_CTL3      = 12'h192;
    localparam logic [11:0] OFS_INT_STAT  = 12'h193;
    localparam logic [11:0] OFS_INT_MASK  = 12'h194;
    localparam logic [7:0]  REG_RST       = 8'h00;
    // Control one fields
    localparam int          C1_OV         = 6;
    localparam int          C1_EN         = 5;
    localparam int          C1_REL        = 4;
    // Control three fields
    localparam int          C3_ACKT       = 7;
    localparam int          C3_STOP_IE    = 6;
    localparam int          C3_START_IE   = 5;
    localparam int          C3_OVW        = 4;
    localparam int          C3_LONG_HOLD  = 3;
    localparam int          C3_COLL       = 2;
    localparam int          C3_AHOLD      = 1;
    localparam int          C3_DHOLD      = 0;
    // Status fields
    localparam int          SF_DATA       = 5;
    localparam int          SF_STOP       = 4;
    localparam int          SF_START      = 3;
    localparam int          SF_READ       = 2;
    localparam int          SF_FULL       = 0;
    // Interrupt events
    localparam int          EV_W          = 6;
    localparam int          EV_BYTE       = 0;
    localparam int          EV_OV         = 1;
    localparam int          EV_COLL       = 2;
    localparam int          EV_HOLD       = 3;
    localparam int          EV_START      = 4;
    localparam int          EV_STOP       = 5;
    // Mode codes
    localparam logic [3:0]  MODE_SPI_LAST = 4'h5;
    localparam logic [3:0]  MODE_CL_7     = 4'h6;
    localparam logic [3:0]  MODE_CL_10    = 4'h7;
    localparam logic [3:0]  MODE_CL_7S    = 4'hE;
    localparam logic [3:0]  MODE_CL_10S   = 4'hF;
    // Bit counts and SDA hold times
    localparam logic [3:0]  SPI_LAST_BIT  = 4'h7;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [3:0]  ACK_BIT       = 4'h9;
    localparam int          CLK_NS        = 8;
    localparam int          HOLD_LONG_NS  = 300;
    localparam int          HOLD_SHORT_NS = 100;
    localparam logic [5:0]  HOLD_LONG_CYC  = 6'((HOLD_LONG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0]  HOLD_SHORT_CYC = 6'((HOLD_SHORT_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_RXD  = 3'b010,
        I_TXD  = 3'b011,
        I_SKIP = 3'b100
    } ssc_state_t;
endpackage : ssc_pkg

// File: core/ssc_top.sv
// Serial port client hold control: registers, I2C client, SPI receive.
// Assumes a register master on SYS_CLK and open-drain pins resolved outside.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module ssc_top (
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST,
    input  wire logic                       CE,
    input  wire logic [ssc_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [7:0]                 WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic      [7:0]                 RDATA,
    output logic                            IRQ,
    input  wire logic                       SCL_I,
    output logic                            SCL_O,
    output logic                            SCL_OE_N,
    input  wire logic                       SDA_I,
    output logic                            SDA_O,
    output logic                            SDA_OE_N
);
    function automatic logic is_client(input logic [3:0] m);
        return m == ssc_pkg::MODE_CL_7 || m == ssc_pkg::MODE_CL_10 ||
               m == ssc_pkg::MODE_CL_7S || m == ssc_pkg::MODE_CL_10S;
    endfunction : is_client

    // Pin synchronisers
    logic [2:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
    logic       scl_l_q, scl_l_d, sda_l_q, sda_l_d;

    always_comb begin
        scl_s_d = {scl_s_q[1:0], SCL_I};
        sda_s_d = {sda_s_q[1:0], SDA_I};
        scl_l_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_l_q;
        sda_l_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_l_q;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_l_q <= 1'b1;
            sda_l_q <= 1'b1;
        end else if (CE) begin
            scl_s_q <= scl_s_d;
            sda_s_q <= sda_s_d;
            scl_l_q <= scl_l_d;
            sda_l_q <= sda_l_d;
        end
    end

    // Registers and protocol state
    logic [7:0]          dbuf_q, dbuf_d, caddr_q, caddr_d, amask_q, amask_d, ctl2_q, ctl2_d;
    logic [7:0]          sh_q, sh_d, tx_q, tx_d, rdata_q, rdata_d;
    logic [1:0]          smp_q, smp_d;
    logic                full_q, full_d, ov_q, ov_d, en_q, en_d, rel_q, rel_d;
    logic                data_q, data_d, read_q, read_d, sta_q, sta_d, sto_q, sto_d;
    logic [3:0]          mode_q, mode_d, cnt_q, cnt_d;
    logic [6:0]          cfg_q, cfg_d;
    logic                ack_time_q, ack_time_d;
    logic [ssc_pkg::EV_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
    ssc_pkg::ssc_state_t st_q, st_d;
    logic [5:0]          hcnt_q, hcnt_d;
    logic                want_q, want_d, sda_oe_n_q, sda_oe_n_d, scl_oe_n_q, scl_oe_n_d;
    logic                irq_q, irq_d;

    logic       client, spi, scl_rise, scl_fall, start, stop, upd, byte_done, ahold, dhold;
    logic [7:0] rx_byte;
    logic [5:0] hold_cyc;

    always_comb begin
        client    = en_q && is_client(mode_q);
        spi       = en_q && mode_q <= ssc_pkg::MODE_SPI_LAST;
        scl_rise  = scl_l_d && !scl_l_q;
        scl_fall  = !scl_l_d && scl_l_q;
        start     = scl_l_q && scl_l_d && sda_l_q && !sda_l_d;
        stop      = scl_l_q && scl_l_d && !sda_l_q && sda_l_d;
        ahold     = client && cfg_q[ssc_pkg::C3_AHOLD];
        dhold     = client && cfg_q[ssc_pkg::C3_DHOLD];
        hold_cyc  = cfg_q[ssc_pkg::C3_LONG_HOLD] ? ssc_pkg::HOLD_LONG_CYC
                                                 : ssc_pkg::HOLD_SHORT_CYC;
        upd       = cfg_q[ssc_pkg::C3_OVW] || (!full_q && (spi || !ov_q));
        byte_done = 1'b0;
        rx_byte   = sh_q;
        ev        = '0;
        dbuf_d = dbuf_q;   caddr_d = caddr_q;   amask_d = amask_q;   ctl2_d = ctl2_q;
        sh_d = sh_q;       tx_d = tx_q;         smp_d = smp_q;       full_d = full_q;
        ov_d = ov_q;       en_d = en_q;         rel_d = rel_q;       mode_d = mode_q;
        data_d = data_q;   read_d = read_q;     sta_d = sta_q;       sto_d = sto_q;
        cfg_d = cfg_q;     ack_time_d = ack_time_q;                  cnt_d = cnt_q;
        ist_d = ist_q;     imask_d = imask_q;   st_d = st_q;         want_d = want_q;
        hcnt_d = (hcnt_q != 6'h00) ? hcnt_q - 6'h01 : hcnt_q;
        sda_oe_n_d = (hcnt_q == 6'h01) ? !want_q : sda_oe_n_q;
        rdata_d = ssc_pkg::REG_RST;

        // Software access first, so that hardware events win the same cycle
        if (RD) begin
            unique case (ADDR)
                ssc_pkg::OFS_DBUF: begin
                    rdata_d = dbuf_q;
                    full_d  = 1'b0;
                end
                ssc_pkg::OFS_CADDR:    rdata_d = caddr_q;
                ssc_pkg::OFS_AMASK:    rdata_d = amask_q;
                ssc_pkg::OFS_STAT:     rdata_d = {smp_q, data_q, sto_q, sta_q, read_q, 1'b0,
                                                  full_q};
                ssc_pkg::OFS_CTL1:     rdata_d = {1'b0, ov_q, en_q, rel_q, mode_q};
                ssc_pkg::OFS_CTL2:     rdata_d = ctl2_q;
                ssc_pkg::OFS_CTL3:     rdata_d = {ack_time_q, cfg_q};
                ssc_pkg::OFS_INT_STAT: rdata_d = 8'({ist_q});
                ssc_pkg::OFS_INT_MASK: rdata_d = 8'({imask_q});
                default:               rdata_d = ssc_pkg::REG_RST;
            endcase
        end
        if (WR) begin
            unique case (ADDR)
                ssc_pkg::OFS_DBUF:     dbuf_d  = WDATA;
                ssc_pkg::OFS_CADDR:    caddr_d = WDATA;
                ssc_pkg::OFS_AMASK:    amask_d = WDATA;
                ssc_pkg::OFS_STAT:     smp_d   = WDATA[7:6];
                ssc_pkg::OFS_CTL1: begin
                    ov_d   = WDATA[ssc_pkg::C1_OV];
                    en_d   = WDATA[ssc_pkg::C1_EN];
                    rel_d  = WDATA[ssc_pkg::C1_REL];
                    mode_d = WDATA[3:0];
                end
                ssc_pkg::OFS_CTL2:     ctl2_d  = WDATA;
                ssc_pkg::OFS_CTL3:     cfg_d   = WDATA[6:0];
                ssc_pkg::OFS_INT_STAT: ist_d   = ist_q & ~WDATA[ssc_pkg::EV_W-1:0];
                ssc_pkg::OFS_INT_MASK: imask_d = WDATA[ssc_pkg::EV_W-1:0];
                default: ;
            endcase
        end

        if (!en_q) begin
            st_d       = ssc_pkg::I_IDLE;
            cnt_d      = 4'h0;
            hcnt_d     = 6'h00;
            want_d     = 1'b0;
            sda_oe_n_d = 1'b1;
            ack_time_d = 1'b0;
        end else if (spi) begin
            ack_time_d = 1'b0;
            if (scl_rise) begin
                sh_d  = {sh_q[6:0], sda_l_q};
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == ssc_pkg::SPI_LAST_BIT) begin
                    cnt_d     = 4'h0;
                    rx_byte   = sh_d;
                    byte_done = 1'b1;
                end
            end
        end else if (client) begin
            if (start) begin
                st_d  = ssc_pkg::I_ADDR;
                cnt_d = 4'h0;
                sta_d = 1'b1;
                sto_d = 1'b0;
                ev[ssc_pkg::EV_START] = cfg_q[ssc_pkg::C3_START_IE];
            end else if (stop) begin
                st_d       = ssc_pkg::I_IDLE;
                sta_d      = 1'b0;
                sto_d      = 1'b1;
                want_d     = 1'b0;
                hcnt_d     = 6'h00;
                sda_oe_n_d = 1'b1;
                ack_time_d = 1'b0;
                ev[ssc_pkg::EV_STOP] = cfg_q[ssc_pkg::C3_STOP_IE];
            end else if (scl_rise && st_q != ssc_pkg::I_IDLE) begin
                cnt_d = cnt_q + 4'h1;
                sh_d  = {sh_q[6:0], sda_l_q};
                if (cnt_q == ssc_pkg::BYTE_BITS) begin
                    ack_time_d = 1'b0;
                    if (st_q == ssc_pkg::I_TXD && sda_l_q) begin
                        st_d = ssc_pkg::I_SKIP;
                    end
                end else if (st_q == ssc_pkg::I_TXD && cfg_q[ssc_pkg::C3_COLL] &&
                             tx_q[7] && !sda_l_q) begin
                    ev[ssc_pkg::EV_COLL] = 1'b1;
                    st_d       = ssc_pkg::I_SKIP;
                    want_d     = 1'b0;
                    hcnt_d     = 6'h00;
                    sda_oe_n_d = 1'b1;
                end
            end else if (scl_fall && st_q != ssc_pkg::I_IDLE) begin
                hcnt_d = hold_cyc;
                want_d = 1'b0;
                if (cnt_q == ssc_pkg::BYTE_BITS) begin
                    unique case (st_q)
                        ssc_pkg::I_ADDR: begin
                            if (((sh_q ^ caddr_q) & amask_q & 8'hFE) == 8'h00) begin
                                byte_done  = 1'b1;
                                want_d     = upd;
                                read_d     = sh_q[0];
                                data_d     = 1'b0;
                                ack_time_d = ahold || dhold;
                                st_d       = sh_q[0] ? ssc_pkg::I_TXD : ssc_pkg::I_RXD;
                                if (ahold) begin
                                    rel_d = 1'b0;
                                    ev[ssc_pkg::EV_HOLD] = 1'b1;
                                end
                            end else begin
                                st_d = ssc_pkg::I_SKIP;
                            end
                        end
                        ssc_pkg::I_RXD: begin
                            byte_done  = 1'b1;
                            want_d     = upd;
                            data_d     = 1'b1;
                            ack_time_d = ahold || dhold;
                            if (dhold) begin
                                rel_d = 1'b0;
                                ev[ssc_pkg::EV_HOLD] = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end else if (cnt_q == ssc_pkg::ACK_BIT) begin
                    cnt_d = 4'h0;
                    if (st_q == ssc_pkg::I_TXD) begin
                        tx_d   = dbuf_q;
                        want_d = !dbuf_q[7];
                        full_d = 1'b0;
                    end
                end else if (st_q == ssc_pkg::I_TXD) begin
                    tx_d   = {tx_q[6:0], 1'b1};
                    want_d = !tx_q[6];
                end
            end
        end else begin
            st_d       = ssc_pkg::I_IDLE;
            ack_time_d = 1'b0;
        end

        if (byte_done) begin
            if (full_q) begin
                ov_d = 1'b1;
                ev[ssc_pkg::EV_OV] = 1'b1;
            end
            if (upd) begin
                dbuf_d = rx_byte;
            end
            full_d = 1'b1;
            ev[ssc_pkg::EV_BYTE] = 1'b1;
        end
        ist_d      = ist_d | ev;
        irq_d      = |(ist_d & imask_d);
        scl_oe_n_d = !(en_d && is_client(mode_d) && !rel_d);
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dbuf_q     <= ssc_pkg::REG_RST;
            caddr_q    <= ssc_pkg::REG_RST;
            amask_q    <= ssc_pkg::REG_RST;
            ctl2_q     <= ssc_pkg::REG_RST;
            sh_q       <= ssc_pkg::REG_RST;
            tx_q       <= ssc_pkg::REG_RST;
            rdata_q    <= ssc_pkg::REG_RST;
            smp_q      <= 2'h0;
            {full_q, ov_q, en_q, rel_q} <= 4'h0;
            {data_q, read_q, sta_q, sto_q} <= 4'h0;
            mode_q     <= 4'h0;
            cnt_q      <= 4'h0;
            cfg_q      <= 7'h00;
            ack_time_q <= 1'b0;
            ist_q      <= '0;
            imask_q    <= '0;
            st_q       <= ssc_pkg::I_IDLE;
            hcnt_q     <= 6'h00;
            want_q     <= 1'b0;
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
            irq_q      <= 1'b0;
        end else if (CE) begin
            dbuf_q     <= dbuf_d;
            caddr_q    <= caddr_d;
            amask_q    <= amask_d;
            ctl2_q     <= ctl2_d;
            sh_q       <= sh_d;
            tx_q       <= tx_d;
            rdata_q    <= rdata_d;
            smp_q      <= smp_d;
            {full_q, ov_q, en_q, rel_q} <= {full_d, ov_d, en_d, rel_d};
            {data_q, read_q, sta_q, sto_q} <= {data_d, read_d, sta_d, sto_d};
            mode_q     <= mode_d;
            cnt_q      <= cnt_d;
            cfg_q      <= cfg_d;
            ack_time_q <= ack_time_d;
            ist_q      <= ist_d;
            imask_q    <= imask_d;
            st_q       <= st_d;
            hcnt_q     <= hcnt_d;
            want_q     <= want_d;
            sda_oe_n_q <= sda_oe_n_d;
            scl_oe_n_q <= scl_oe_n_d;
            irq_q      <= irq_d;
        end
    end

    assign RDATA    = rdata_q;
    assign IRQ      = irq_q;
    assign SCL_OE_N = scl_oe_n_q;
    assign SDA_OE_N = sda_oe_n_q;
    assign SCL_O    = 1'b0 & scl_oe_n_q;
    assign SDA_O    = 1'b0 & sda_oe_n_q;

    // Checks: cycles since the last SCL fall
    logic [5:0] since_fall_q;
    always_ff @(posedge SYS_CLK) begin
        if (RST || scl_fall) begin
            since_fall_q <= 6'h00;
        end else if (since_fall_q != 6'h3F) begin
            since_fall_q <= since_fall_q + 6'h01;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST || !CE);

    property p_sda_hold;
        (client && !scl_l_q && $changed(sda_oe_n_q) && $stable(cfg_q))
            |-> since_fall_q >= hold_cyc;
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("SDA changed inside hold time");

    property p_coll_cause;
        $rose(ist_q[ssc_pkg::EV_COLL]) |-> $past(cfg_q[ssc_pkg::C3_COLL]) && $past(client);
    endproperty
    a_coll_cause: assert property (p_coll_cause) else $error("Collision flag without enable");

    property p_mode_ignore;
        (!client && !(WR && ADDR == ssc_pkg::OFS_CTL1)) |=> $stable(rel_q) && !ack_time_q;
    endproperty
    a_mode_ignore: assert property (p_mode_ignore) else $error("Hold acted outside client");

    property p_addr_hold;
        (ahold && scl_fall && st_q == ssc_pkg::I_ADDR && cnt_q == ssc_pkg::BYTE_BITS &&
         ((sh_q ^ caddr_q) & amask_q & 8'hFE) == 8'h00) |=> !rel_q && !SCL_OE_N;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("Address hold missed");

    property p_data_hold;
        (dhold && scl_fall && st_q == ssc_pkg::I_RXD && cnt_q == ssc_pkg::BYTE_BITS)
            |=> !rel_q && data_q;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("Data hold missed");

    property p_ack_time_drop;
        (client && scl_rise && cnt_q == ssc_pkg::BYTE_BITS && !start && !stop)
            |=> !ack_time_q && cnt_q == ssc_pkg::ACK_BIT;
    endproperty
    a_ack_time_drop: assert property (p_ack_time_drop) else $error("Ack time not dropped");

    property p_overwrite;
        (byte_done && full_q && cfg_q[ssc_pkg::C3_OVW]) |=> ov_q && dbuf_q == $past(rx_byte);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("Overwrite byte lost");

    property p_no_overwrite;
        (byte_done && full_q && !cfg_q[ssc_pkg::C3_OVW] && !(WR && ADDR == ssc_pkg::OFS_DBUF))
            |=> ov_q && $stable(dbuf_q) && ist_q[ssc_pkg::EV_OV];
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) else $error("Full buffer was changed");

    property p_stretch;
        (client && !rel_q && !(WR && ADDR == ssc_pkg::OFS_CTL1)) |=> !SCL_OE_N;
    endproperty
    a_stretch: assert property (p_stretch) else $error("SCL not held low");

    c_addr_hold: cover property (ahold && scl_fall && st_q == ssc_pkg::I_ADDR ##1 !rel_q);
    c_overflow:  cover property (byte_done && full_q);
    c_collision: cover property ($rose(ist_q[ssc_pkg::EV_COLL]));
    c_read_xfer: cover property (st_q == ssc_pkg::I_TXD && scl_fall);
endmodule : ssc_top

// File: dv/ssc_host_model.sv
// I2C host and SPI byte source driving the client's SCL and SDA pins.
// Assumes open-drain pins with pull-ups and active-low client enables.
`timescale 1ns/100ps
module ssc_host_model (
    input  wire logic clk,
    input  wire logic scl_oe_n,
    input  wire logic sda_oe_n,
    output logic      scl,
    output logic      sda
);
    logic scl_h = 1'b1;
    logic sda_h = 1'b1;
    assign scl = scl_h & scl_oe_n;
    assign sda = sda_h & sda_oe_n;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One SCL high phase; waits out a stretch
    task automatic pulse(output logic s);
        int i;
        scl_h <= 1'b1;
        for (i = 0; i < 100 && scl !== 1'b1; i++) tick(1);
        tick(5);
        s = sda;
        tick(5);
        scl_h <= 1'b0;
    endtask : pulse
    task automatic spi(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            scl_h <= 1'b0;
            sda_h <= b[i];
            tick(10);
            scl_h <= 1'b1;
            tick(10);
        end
    endtask : spi
    task automatic start();
        sda_h <= 1'b1;
        tick(10);
        sda_h <= 1'b0;
        tick(10);
        scl_h <= 1'b0;
    endtask : start
    // Eight bits, then cycles from last fall until the client acks
    task automatic byte8(input logic [7:0] b, output int h);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            tick(5);
            sda_h <= b[i];
            tick(5);
            pulse(s);
        end
        tick(2);
        sda_h <= 1'b1;
        for (h = 2; h < 100 && sda_oe_n !== 1'b0; h++) tick(1);
    endtask : byte8
    task automatic ack9(output logic a);
        pulse(a);
        tick(60);
    endtask : ack9
    task automatic stop();
        sda_h <= 1'b0;
        tick(5);
        scl_h <= 1'b1;
        tick(10);
        sda_h <= 1'b1;
        tick(10);
    endtask : stop
endmodule : ssc_host_model

// File: dv/tb_top.sv
// Self-checking bench for the serial port client hold control block.
// Assumes ssc_pkg, ssc_top and the host model are compiled before it.
`timescale 1ns/100ps
module tb_top;
    localparam logic [11:0] C1  = ssc_pkg::OFS_CTL1;
    localparam logic [11:0] C3  = ssc_pkg::OFS_CTL3;
    localparam logic [11:0] BUF = ssc_pkg::OFS_DBUF;
    localparam logic [11:0] IMK = ssc_pkg::OFS_INT_MASK;
    localparam int          HL  = ssc_pkg::HOLD_LONG_CYC;
    localparam int          HS  = ssc_pkg::HOLD_SHORT_CYC;
    logic        SYS_CLK, RST, CE, WR, RD, SCL_I, SDA_I, IRQ, SCL_OE_N, SDA_OE_N, a;
    logic [11:0] ADDR;
    logic [7:0]  WDATA, RDATA;
    int          fail_count = 0, checks = 0, cyc = 0, h;
    ssc_top ssc_top_inst (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .SCL_I(SCL_I), .SCL_O(),
        .SCL_OE_N(SCL_OE_N), .SDA_I(SDA_I), .SDA_O(), .SDA_OE_N(SDA_OE_N));
    ssc_host_model ssc_host_model_inst (.clk(SYS_CLK), .scl_oe_n(SCL_OE_N),
        .sda_oe_n(SDA_OE_N), .scl(SCL_I), .sda(SDA_I));
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    task automatic complete_run();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
        @(posedge SYS_CLK);
        WR    <= 1'b1;
        ADDR  <= ad;
        WDATA <= dt;
        @(posedge SYS_CLK);
        WR    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] ad, input logic [7:0] exp);
        @(posedge SYS_CLK);
        RD   <= 1'b1;
        ADDR <= ad;
        @(posedge SYS_CLK);
        RD   <= 1'b0;
        #1 chk(RDATA, exp);
    endtask : rd
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        {RST, CE, WR, RD, ADDR, WDATA} = {2'b11, 2'b00, 12'h000, 8'h00};
        repeat (5) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd(C3, 8'h00);
        rd(12'h18B, 8'h00);
        // SPI with hold bits set: no stretching
        wr(C3, 8'h1B);
        wr(C1, 8'h20);
        ssc_host_model_inst.spi(8'h5A);
        ssc_host_model_inst.spi(8'hC3);
        #1 chk({7'h0, SCL_OE_N}, 8'h01);
        rd(BUF, 8'hC3);
        rd(C1, 8'h60);
        wr(C1, 8'h20);
        wr(C3, 8'h0B);
        ssc_host_model_inst.spi(8'h11);
        ssc_host_model_inst.spi(8'h22);
        rd(BUF, 8'h11);
        rd(C1, 8'h60);
        // I2C client, address then data hold
        wr(C1, 8'h00);
        wr(ssc_pkg::OFS_CADDR, 8'hA0);
        wr(ssc_pkg::OFS_AMASK, 8'hFE);
        wr(IMK, 8'h08);
        wr(C3, 8'h0B);
        wr(C1, 8'h36);
        ssc_host_model_inst.start();
        ssc_host_model_inst.byte8(8'hA0, h);
        chk({7'h0, h >= HL && h <= HL + 12}, 8'h01);
        rd(C3, 8'h8B);
        rd(C1, 8'h26);
        chk({7'h0, SCL_OE_N}, 8'h00);
        chk({7'h0, IRQ}, 8'h01);
        wr(IMK, 8'h00);
        repeat (2) @(posedge SYS_CLK);
        #1 chk({7'h0, IRQ}, 8'h00);
        wr(IMK, 8'h08);
        wr(ssc_pkg::OFS_INT_STAT, 8'h3F);
        repeat (2) @(posedge SYS_CLK);
        #1 chk({7'h0, IRQ}, 8'h00);
        rd(BUF, 8'hA0);
        wr(C3, 8'h03);
        wr(C1, 8'h36);
        ssc_host_model_inst.ack9(a);
        chk({7'h0, a}, 8'h00);
        chk({7'h0, SCL_OE_N}, 8'h01);
        rd(C3, 8'h03);
        ssc_host_model_inst.byte8(8'h3C, h);
        chk({7'h0, h >= HS && h <= HS + 12}, 8'h01);
        rd(C1, 8'h26);
        rd(C3, 8'h83);
        chk({7'h0, IRQ}, 8'h01);
        rd(BUF, 8'h3C);
        wr(C1, 8'h36);
        ssc_host_model_inst.ack9(a);
        chk({7'h0, a}, 8'h00);
        ssc_host_model_inst.stop();
        // Read address, then the host pulls a released one bit low
        wr(C3, 8'h04);
        ssc_host_model_inst.start();
        ssc_host_model_inst.byte8(8'hA1, h);
        chk({7'h0, h >= HS && h <= HS + 12}, 8'h01);
        wr(BUF, 8'hFF);
        wr(ssc_pkg::OFS_INT_STAT, 8'h3F);
        ssc_host_model_inst.ack9(a);
        chk({7'h0, a}, 8'h00);
        ssc_host_model_inst.byte8(8'h00, h);
        chk({7'h0, SDA_OE_N}, 8'h01);
        rd(ssc_pkg::OFS_INT_STAT, 8'h04);
        ssc_host_model_inst.ack9(a);
        ssc_host_model_inst.stop();
        complete_run();
    end
endmodule : tb_top
